// >>> src/rws_defs.vh
`ifndef RWS_DEFS_VH
`define RWS_DEFS_VH
// ****************************************
// Register map (byte offsets)
// ****************************************
`define RWS_ADDR_CTRL 12'h000
`define RWS_ADDR_STAT 12'h004
`define RWS_ADDR_CFG 12'h008
`define RWS_ADDR_WAKE 12'h00C
`define RWS_ADDR_PC 12'h010
// ****************************************
// Control fields
// ****************************************
`define RWS_CTRL_SWDT 0
`define RWS_CTRL_SLEEP 1
`define RWS_CTRL_CLRWDT 2
`define RWS_CTRL_PROG 3
// ****************************************
// Status fields (cause bits)
// ****************************************
`define RWS_ST_POR 0
`define RWS_ST_BOR 1
`define RWS_ST_MASTER_CLEAR_PIN 2
`define RWS_ST_MASTER_CLEAR_PIN_SLP 3
`define RWS_ST_WDT 4
`define RWS_ST_WDT_WAKE 5
`define RWS_ST_INT_WAKE 6
`define RWS_ST_ASLEEP 7
`define RWS_ST_INRESET 8
// ****************************************
// Configuration word (bits are 0 when programmed)
// ****************************************
`define RWS_CFG_LOC 14'h2007
`define RWS_CFG_RESET 14'h3FFF
`define RWS_CFG_OSC_LO 0
`define RWS_CFG_OSC_HI 2
`define RWS_CFG_WDTE 3
`define RWS_CFG_PWRTE 4
`define RWS_CFG_BORV_LO 5
`define RWS_CFG_BORV_HI 6
`define RWS_CFG_CP 7
// ****************************************
// Vectors and timing
// ****************************************
`define RWS_INT_VECTOR 13'h0004
`define RWS_CLK_MHZ 125
`define RWS_POWER_UP_DELAY_TIMER_MS 72
`define RWS_POWER_UP_DELAY_TIMER_CYC (`RWS_POWER_UP_DELAY_TIMER_MS * 1000 * `RWS_CLK_MHZ)
`define RWS_OST_CYC 1024
`define RWS_MASTER_CLEAR_PIN_FILT_CYC 16
`define RWS_WDT_CYC 2304
`endif

// >>> src/rws_sequencer.v
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "rws_defs.vh"

module rws_sequencer #(
  parameter POWER_UP_DELAY_TIMER_CYC = `RWS_POWER_UP_DELAY_TIMER_CYC
)
(
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Reset sources
  input wire por_event,
  input wire supply_drop_reset,
  input wire master_clear_pin_n,
  input wire wdt_rc_tick,
  input wire osc_ready,
  // Core side
  input wire irq_pending,
  input wire global_interrupt_enable,
  input wire [12:0] core_pc,
  output reg core_reset,
  output reg core_wake,
  output reg [12:0] wake_pc,
  output reg retained_clear,
  // Switch-mode controller side
  output reg switch_mode_output_controller_reset,
  output reg switch_mode_output_controller_gate,
  output reg [1:0] smc_out_oe_n,
  input wire [1:0] smc_out_raw,
  output reg [1:0] smc_out
);

// ****************************************
// State codes
// ****************************************
localparam ST_RESET = 2'd0;
localparam ST_RUN = 2'd1;
localparam ST_SLEEP = 2'd2;

// ****************************************
// Storage
// ****************************************
reg [1:0] state; // Run/sleep/reset
reg [13:0] cfg_word; // Configuration word, active low bits
reg sw_wdt_en; // Software watchdog enable
reg prog_mode; // Programming mode window
reg [8:0] cause; // Sticky cause bits
reg [31:0] power_up_delay_timer_cnt; // Power-up delay count
reg power_up_delay_timer_done;
reg [10:0] ost_cnt; // Oscillator settle count
reg ost_done;
reg [4:0] master_clear_pin_cnt; // Filter count of low samples
reg master_clear_pin_rst; // Filtered master clear
reg [11:0] wdt_cnt; // Watchdog count in RC ticks
reg power_up; // Power-up class reset in progress
wire por_any = por_event | supply_drop_reset;
wire wdt_on = ~cfg_word[`RWS_CFG_WDTE] | sw_wdt_en;
wire power_up_delay_timer_use = ~cfg_word[`RWS_CFG_PWRTE];
wire wdt_to = wdt_on & (wdt_cnt == `RWS_WDT_CYC);
wire acc = psel & penable & pready;
wire wr = acc & pwrite;
wire clr_wdt = wr & (paddr == `RWS_ADDR_CTRL) & pwdata[`RWS_CTRL_CLRWDT];

// ****************************************
// Master clear noise filter
// ****************************************
// Low must persist for a run of samples; a short glitch is dropped
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    master_clear_pin_cnt <= 5'd0;
    master_clear_pin_rst <= 1'b0;
  end
  else if (master_clear_pin_n)
  begin
    master_clear_pin_cnt <= 5'd0;
    master_clear_pin_rst <= 1'b0;
  end
  else if (master_clear_pin_cnt == `RWS_MASTER_CLEAR_PIN_FILT_CYC)
    master_clear_pin_rst <= 1'b1;
  else
    master_clear_pin_cnt <= master_clear_pin_cnt + 5'd1;
end

// ****************************************
// Watchdog counter on RC ticks
// ****************************************
// Counts only the RC tick so the main clock rate never shifts the timeout
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    wdt_cnt <= 12'h000;
  else if (!wdt_on || clr_wdt || wdt_to || core_reset)
    wdt_cnt <= 12'h000;
  else if (wdt_rc_tick)
    wdt_cnt <= wdt_cnt + 12'h001;
end

// ****************************************
// Start-up timers
// ****************************************
// Power-up delay only after power class resets; settle timer after any
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    power_up_delay_timer_cnt <= 32'h0000_0000;
    power_up_delay_timer_done <= 1'b0;
    ost_cnt <= 11'h000;
    ost_done <= 1'b0;
    power_up <= 1'b1;
  end
  else if (por_any || master_clear_pin_rst || (wdt_to && state == ST_RUN))
  begin
    power_up_delay_timer_cnt <= 32'h0000_0000;
    power_up_delay_timer_done <= 1'b0;
    ost_cnt <= 11'h000;
    ost_done <= 1'b0;
    if (por_any)
      power_up <= 1'b1;
  end
  else
  begin
    if (!power_up_delay_timer_use || !power_up || power_up_delay_timer_cnt == POWER_UP_DELAY_TIMER_CYC)
      power_up_delay_timer_done <= 1'b1;
    else
      power_up_delay_timer_cnt <= power_up_delay_timer_cnt + 32'h0000_0001;
    if (osc_ready && ost_cnt == `RWS_OST_CYC)
      ost_done <= 1'b1;
    else if (osc_ready)
      ost_cnt <= ost_cnt + 11'h001;
    if (power_up_delay_timer_done && ost_done)
      power_up <= 1'b0;
  end
end

// ****************************************
// Sequencer, causes and outputs
// ****************************************
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    state <= ST_RESET;
    cause <= 9'h001;
    core_reset <= 1'b1;
    core_wake <= 1'b0;
    wake_pc <= 13'h0000;
    retained_clear <= 1'b1;
    switch_mode_output_controller_reset <= 1'b1;
    switch_mode_output_controller_gate <= 1'b1;
    sw_wdt_en <= 1'b0;
  end
  else
  begin
    core_wake <= 1'b0;
    retained_clear <= 1'b0;
    case (state)
      ST_RESET:
      begin
        if (!por_any && !master_clear_pin_rst && power_up_delay_timer_done && ost_done)
        begin
          state <= ST_RUN;
          core_reset <= 1'b0;
          switch_mode_output_controller_reset <= 1'b0;
          switch_mode_output_controller_gate <= 1'b0;
        end
      end
      ST_RUN:
      begin
        if (wr && paddr == `RWS_ADDR_CTRL && pwdata[`RWS_CTRL_SLEEP])
        begin
          state <= ST_SLEEP;
          switch_mode_output_controller_gate <= 1'b1;
          cause[`RWS_ST_ASLEEP] <= 1'b1;
        end
      end
      ST_SLEEP:
      begin
        if (wdt_to || (irq_pending && !master_clear_pin_rst && !por_any))
        begin
          state <= ST_RUN;
          core_wake <= 1'b1;
          switch_mode_output_controller_gate <= 1'b0;
          cause <= {1'b0, 1'b0, ~wdt_to, wdt_to, 5'h00};
          if (!wdt_to && global_interrupt_enable)
            wake_pc <= `RWS_INT_VECTOR;
          else
            wake_pc <= core_pc + 13'h0001;
        end
      end
      default:
        state <= ST_RESET;
    endcase
    // Reset sources override, power class takes precedence
    if (por_any || master_clear_pin_rst || (wdt_to && state == ST_RUN))
    begin
      state <= ST_RESET;
      core_reset <= 1'b1;
      // A reset that lands with a wake event wins; the core never sees both
      core_wake <= 1'b0;
      sw_wdt_en <= 1'b0;
      switch_mode_output_controller_reset <= 1'b1;
      switch_mode_output_controller_gate <= 1'b1;
      retained_clear <= por_any;
      if (por_event)
        cause <= 9'h101;
      else if (supply_drop_reset)
        cause <= 9'h102;
      else if (master_clear_pin_rst)
        cause <= (state == ST_SLEEP) ? 9'h108 : 9'h104;
      else
        cause <= 9'h110;
    end
    else
    begin
      cause[`RWS_ST_INRESET] <= (state == ST_RESET);
      if (wr && paddr == `RWS_ADDR_CTRL)
        sw_wdt_en <= pwdata[`RWS_CTRL_SWDT];
    end
  end
end

// ****************************************
// Switch-mode pins
// ****************************************
// Pins float (inputs) while in reset; outputs forced inactive in sleep
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    smc_out <= 2'b00;
    smc_out_oe_n <= 2'b11;
  end
  else
  begin
    smc_out <= switch_mode_output_controller_gate ? 2'b00 : smc_out_raw;
    smc_out_oe_n <= {2{switch_mode_output_controller_reset}};
  end
end

// ****************************************
// APB slave, zero wait states
// ****************************************
// Config word held in programming mode only; only presetn resets it, so straps persist across the other reset sources
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    prdata <= 32'h0000_0000;
    pready <= 1'b0;
    pslverr <= 1'b0;
    prog_mode <= 1'b0;
    cfg_word <= `RWS_CFG_RESET;
  end
  else
  begin
    pready <= psel & ~penable;
    pslverr <= 1'b0;
    if (psel && !penable)
    begin
      prdata <= 32'h0000_0000;
      case (paddr)
        `RWS_ADDR_CTRL:
          prdata <= {28'h000_0000, prog_mode, 1'b0, state == ST_SLEEP, sw_wdt_en};
        `RWS_ADDR_STAT:
          prdata <= {23'h00_0000, cause};
        `RWS_ADDR_CFG:
          if (prog_mode)
            prdata <= {18'h0_0000, cfg_word};
          else
            pslverr <= 1'b1;
        `RWS_ADDR_WAKE:
          prdata <= {19'h0_0000, wake_pc};
        `RWS_ADDR_PC:
          prdata <= {18'h0_0000, `RWS_CFG_LOC};
        default:
          pslverr <= 1'b1;
      endcase
      if (pwrite && paddr == `RWS_ADDR_CFG && !prog_mode)
        pslverr <= 1'b1;
    end
    if (wr && paddr == `RWS_ADDR_CTRL)
      prog_mode <= pwdata[`RWS_CTRL_PROG] & core_reset;
    if (wr && paddr == `RWS_ADDR_CFG && prog_mode)
      cfg_word <= cfg_word & pwdata[13:0];
  end
end

endmodule
`default_nettype wire

// >>> tb/rws_sequencer_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module rws_sequencer_sva (
  // Clock, reset and sources
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_event,
  input wire logic supply_drop_reset,
  input wire logic osc_ready,
  // Watched outputs
  input wire logic pready,
  input wire logic core_reset,
  input wire logic core_wake,
  input wire logic switch_mode_output_controller_reset,
  input wire logic switch_mode_output_controller_gate,
  input wire logic [1:0] smc_out_oe_n,
  input wire logic [1:0] smc_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Start-up timers always follow a release
  AST_HOLD_AFTER_RELEASE: assert property ($rose(presetn) |-> core_reset)
    else $error("core released with the reset line");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  // Settle timer runs long after the oscillator came up
  AST_OSC_BEFORE_RUN: assert property ($fell(core_reset) |-> $past(osc_ready, 8))
    else $error("core released without a settled oscillator");
  AST_SOURCES_CLEAR: assert property ($fell(core_reset) |->
    !$past(por_event) && !$past(supply_drop_reset))
    else $error("core released while a supply source is active");
  // A stopped oscillator must not leave the power stage driven
  AST_SLEEP_GATE: assert property (switch_mode_output_controller_gate &&
    $past(switch_mode_output_controller_gate) |-> smc_out == 2'b00)
    else $error("switch-mode output active while gated");
  AST_RESET_FLOAT: assert property (switch_mode_output_controller_reset &&
    $past(switch_mode_output_controller_reset) |-> smc_out_oe_n == 2'b11)
    else $error("switch-mode pins driven in reset");
  AST_WAKE_NO_RESET: assert property (core_wake |-> !core_reset)
    else $error("wake came with a core reset");
  AST_WAKE_PULSE: assert property (core_wake |=> !core_wake)
    else $error("wake pulse longer than one cycle");
endmodule
bind rws_sequencer rws_sequencer_sva u_sva (
  .pclk(pclk),
  .presetn(presetn),
  .por_event(por_event),
  .supply_drop_reset(supply_drop_reset),
  .osc_ready(osc_ready),
  .pready(pready),
  .core_reset(core_reset),
  .core_wake(core_wake),
  .switch_mode_output_controller_reset(switch_mode_output_controller_reset),
  .switch_mode_output_controller_gate(switch_mode_output_controller_gate),
  .smc_out_oe_n(smc_out_oe_n),
  .smc_out(smc_out)
);
`default_nettype wire

// >>> tb/rws_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Core and power stage model
// ****************************************
module rws_core_model (
  // Clock and hold
  input wire logic pclk,
  input wire logic core_reset,
  input wire logic gate,
  // Switch-mode pins
  input wire logic [1:0] smc_out,
  input wire logic [1:0] smc_out_oe_n,
  // Core state
  input wire logic irq_req,
  output logic irq_pending,
  output logic [12:0] core_pc,
  output logic [1:0] smc_out_raw,
  output logic [1:0] smc_pin
);
  // PC freezes while gated, as the core clock is stopped in sleep
  always @(posedge pclk)
    if (core_reset)
      core_pc <= 13'h0000;
    else if (!gate)
      core_pc <= core_pc + 13'h0001;
  // Pending interrupt follows the bench request
  assign irq_pending = irq_req;
  // Programmed pattern, kept across sleep
  assign smc_out_raw = 2'b10;
  // Off-state bias keeps the power device off when undriven
  assign smc_pin = smc_out & ~smc_out_oe_n;
endmodule
`default_nettype wire

// >>> tb/reset_and_wake_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "rws_defs.vh"
module reset_and_wake_sequencer_tb;
  // ****************************************
  // Stimulus and state
  // ****************************************
  localparam integer POWER_UP_DELAY_TIMER = 100; // Shortened delay keeps the run brief
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, por_event = 1'b0;
  logic supply_drop_reset = 1'b0, master_clear_pin_n = 1'b1, wdt_rc_tick = 1'b0;
  logic osc_ready = 1'b0, irq_req = 1'b0, global_interrupt_enable = 1'b0;
  logic tick_en = 1'b0, seen_clr = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  wire [31:0] prdata;
  wire pready, pslverr, core_reset, core_wake, retained_clear, smc_rst, gate, irq_pending;
  wire [12:0] core_pc, wake_pc;
  wire [1:0] smc_out_oe_n, smc_out_raw, smc_out, smc_pin;
  integer n_mismatch = 0, n_tests = 0, seed = 32'ha5a1d278, cyc, i;
  rws_sequencer #(.POWER_UP_DELAY_TIMER_CYC(POWER_UP_DELAY_TIMER)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .por_event(por_event),
    .supply_drop_reset(supply_drop_reset), .master_clear_pin_n(master_clear_pin_n),
    .wdt_rc_tick(wdt_rc_tick), .osc_ready(osc_ready), .irq_pending(irq_pending),
    .global_interrupt_enable(global_interrupt_enable), .core_pc(core_pc),
    .core_reset(core_reset), .core_wake(core_wake), .wake_pc(wake_pc),
    .retained_clear(retained_clear), .switch_mode_output_controller_reset(smc_rst),
    .switch_mode_output_controller_gate(gate), .smc_out_oe_n(smc_out_oe_n),
    .smc_out_raw(smc_out_raw), .smc_out(smc_out));
  rws_core_model u_core (.pclk(pclk), .core_reset(core_reset), .gate(gate),
    .smc_out(smc_out), .smc_out_oe_n(smc_out_oe_n), .irq_req(irq_req),
    .irq_pending(irq_pending), .core_pc(core_pc), .smc_out_raw(smc_out_raw),
    .smc_pin(smc_pin));
  initial
    forever #4 pclk = ~pclk;
  // Watchdog RC ticks at half rate, unrelated to the core's own work
  always @(posedge pclk)
    wdt_rc_tick <= tick_en & ~wdt_rc_tick;
  // Remember any clear of retained state
  always @(posedge pclk)
    if (retained_clear === 1'b1)
      seen_clr <= 1'b1;
  task chk(input [31:0] got, input [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request stands until ready is sampled
  task apb(input [11:0] a, input w, input [31:0] d);
    integer k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge pclk);
      k = k + 1;
    end
    rd = prdata;
    err = pslverr;
    if (k == 20)
      n_mismatch = n_mismatch + 1;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait: 0 core running, 1 core held, 2 wake pulse
  task wt(input [1:0] s, input integer lim);
    cyc = 0;
    while (!(s == 0 ? core_reset === 1'b0 : s == 1 ? core_reset === 1'b1 :
      core_wake === 1'b1) && cyc < lim)
    begin
      @(posedge pclk);
      cyc = cyc + 1;
    end
    if (cyc == lim)
      n_mismatch = n_mismatch + 1;
  endtask
  function [12:0] exp_wake(input vec, input [12:0] pc);
    exp_wake = vec ? `RWS_INT_VECTOR : pc + 13'h0001;
  endfunction
  // Sleep, then wake by interrupt (v) or by watchdog
  task nap(input g, input v);
    global_interrupt_enable <= g;
    tick_en <= ~v;
    apb(`RWS_ADDR_CTRL, 1'b1, v ? 32'h0000_0002 : 32'h0000_0003);
    repeat (4) @(posedge pclk);
    chk(smc_out, 2'b00);
    irq_req <= v;
    wt(2, 6000);
    chk(wake_pc, exp_wake(g & v, core_pc));
    irq_req <= 1'b0;
    tick_en <= 1'b0;
    apb(`RWS_ADDR_STAT, 1'b0, 32'h0000_0000);
    chk(rd[v ? 6 : 5], 1'b1);
    chk(smc_out, 2'b10);
  endtask
  task give_verdict;
    if (n_mismatch == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(`RWS_ADDR_CTRL, 1'b1, 32'h0000_0008);
    apb(`RWS_ADDR_CFG, 1'b1, 32'h0000_3FEF);
    apb(`RWS_ADDR_CFG, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_3FEF);
    apb(`RWS_ADDR_PC, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_2007);
    apb(`RWS_ADDR_CTRL, 1'b1, 32'h0000_0000);
    apb(`RWS_ADDR_CFG, 1'b0, 32'h0000_0000);
    chk(err, 1'b1);
    chk(smc_pin, 2'b00);
    osc_ready <= 1'b1;
    wt(0, 3000);
    chk(cyc >= 1024, 1'b1);
    apb(12'h0FC, 1'b0, 32'h0000_0000);
    chk(err, 1'b1);
    apb(`RWS_ADDR_STAT, 1'b0, 32'h0000_0000);
    chk(rd[0], 1'b1);
    seen_clr <= 1'b0;
    supply_drop_reset <= 1'b1;
    repeat (4) @(posedge pclk);
    supply_drop_reset <= 1'b0;
    wt(0, 3000);
    chk(cyc >= POWER_UP_DELAY_TIMER, 1'b1);
    chk(seen_clr, 1'b1);
    apb(`RWS_ADDR_STAT, 1'b0, 32'h0000_0000);
    chk(rd[1], 1'b1);
    seen_clr <= 1'b0;
    for (i = 0; i < 8; i = i + 1)
    begin
      master_clear_pin_n <= 1'b0;
      repeat (1 + {$random(seed)} % 15) @(posedge pclk);
      master_clear_pin_n <= 1'b1;
      repeat (20) @(posedge pclk);
      chk(core_reset, 1'b0);
    end
    master_clear_pin_n <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(core_reset, 1'b1);
    master_clear_pin_n <= 1'b1;
    wt(0, 3000);
    chk(seen_clr, 1'b0);
    apb(`RWS_ADDR_STAT, 1'b0, 32'h0000_0000);
    chk(rd[2], 1'b1);
    nap(1'b1, 1'b1);
    nap(1'b0, 1'b1);
    nap(1'b0, 1'b0);
    apb(`RWS_ADDR_CTRL, 1'b1, 32'h0000_0001);
    tick_en <= 1'b1;
    wt(1, 6000);
    tick_en <= 1'b0;
    wt(0, 3000);
    apb(`RWS_ADDR_STAT, 1'b0, 32'h0000_0000);
    chk(rd[4], 1'b1);
    give_verdict;
  end
  initial
  begin
    repeat (40000) @(posedge pclk);
    n_mismatch = n_mismatch + 1;
    give_verdict;
  end
endmodule
`default_nettype wire
